// ---- logic/vsb_ctrl.sv ----
// Suction mode, blowoff, part-present and freedrive sequencing of the vacuum gripper
`timescale 1ns/1ps
module vsb_ctrl
  import vsb_pkg::*;
#(
  parameter int          HOLD_CNT     = HOLD_CYCLES,
  parameter int          RELEASE_CNT  = RELEASE_CYCLES,
  parameter int          BLOW_UNIT    = BLOWOFF_UNIT_CYCLES,
  parameter logic [15:0] FULL_SCALE   = 16'h03e8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         io_link_mode,
  input  wire logic         suction_request_input,
  input  wire logic         blowoff_request_input,
  input  wire logic         button_left,
  input  wire logic         button_right,
  input  wire logic         polarity_switch_inputs,
  input  wire logic         polarity_switch_output,
  input  wire logic [15:0]  vacuum_raw,
  input  wire logic         device_error,
  input  wire logic         threshold_adjust_active,
  input  wire vsb_pd_out_t  pd_out,
  input  wire vsb_par_req_t par_req,
  output vsb_pd_in_t        pd_in,
  output logic [15:0]       par_rdata,
  output logic              par_rvalid,
  output logic              part_present_output,
  output logic              manual_guide_output,
  output logic              manual_guide_sourcing,
  output logic              pump_run,
  output logic              regulate_mode,
  output logic [7:0]        pump_power_percent,
  output logic [15:0]       regulation_target,
  output logic [15:0]       vacuum_corrected,
  output logic              blowoff_valve,
  output logic              freedrive_indicator
);

  typedef enum logic [1:0] {
    FD_IDLE,
    FD_REQUESTED,
    FD_ACTIVE
  } vsb_fd_state_t;

  localparam int CNT_W = $clog2((HOLD_CNT > RELEASE_CNT ? HOLD_CNT : RELEASE_CNT) + 1);
  localparam int UNIT_W = $clog2(BLOW_UNIT + 1);

  initial begin
    if (HOLD_CNT < 1 || RELEASE_CNT < 1 || BLOW_UNIT < 1) begin
      $error("vsb_ctrl: time counts must be at least one cycle");
    end
  end

  logic [7:0]    blowoff_mode_select_ff;
  logic [7:0]    suction_mode_select_ff;
  logic [15:0]   regulation_setpoint_value_ff;
  logic [7:0]    pump_speed_percent_ff;
  logic [15:0]   part_present_threshold_ff;
  logic [15:0]   part_present_hysteresis_ff;
  logic [15:0]   blowoff_duration_ff;
  logic [7:0]    ext_locks_ff;
  logic [15:0]   zero_offset_ff;
  logic          zero_error_ff;
  logic [3:0]    pins_sync;
  logic [1:0]    pol_sync;
  logic          suction_req;
  logic          blowoff_req;
  logic          blowoff_req_d_ff;
  logic          suction_d_ff;
  logic          suction_active;
  logic          timed_blow;
  logic [15:0]   blow_ms_ff;
  logic [UNIT_W-1:0] blow_unit_ff;
  logic          part_present_ff;
  vsb_fd_state_t fd_state_ff;
  vsb_fd_state_t nxt_fd_state;
  logic [CNT_W-1:0] hold_cnt_ff;
  logic [CNT_W-1:0] rel_cnt_ff;
  logic          both_pressed;
  logic          any_pressed;
  logic          fd_allowed;
  logic          cont_mode;
  logic [7:0]    power_pct;

  function automatic logic [7:0] clamp_percent(input logic [7:0] value);
    clamp_percent = (value > PERCENT_FULL) ? PERCENT_FULL : value;
  endfunction

  function automatic logic [15:0] abs16(input logic [15:0] value);
    abs16 = value[15] ? 16'(-value) : value;
  endfunction

  // Pin inputs come from outside the clock domain
  vsb_sync #(
    .WIDTH (4)
  ) u_pin_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({button_right, button_left, blowoff_request_input, suction_request_input}),
    .level (pins_sync)
  );

  vsb_sync #(
    .WIDTH (2)
  ) u_pol_sync (
    .clk   (clk),
    .rst   (rst),
    .pin   ({polarity_switch_output, polarity_switch_inputs}),
    .level (pol_sync)
  );

  // Parameter writes from the acyclic channel
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blowoff_mode_select_ff       <= RST_BLOWOFF_MODE;
      suction_mode_select_ff       <= RST_SUCTION_MODE;
      regulation_setpoint_value_ff <= RST_REG_SETPOINT;
      pump_speed_percent_ff        <= RST_PUMP_SPEED;
      part_present_threshold_ff    <= RST_PP_THRESHOLD;
      part_present_hysteresis_ff   <= RST_PP_HYSTERESIS;
      blowoff_duration_ff          <= RST_BLOWOFF_TIME;
      ext_locks_ff                 <= RST_EXT_LOCKS;
    end else if (par_req.wr) begin
      case (par_req.index)
        IDX_BLOWOFF_MODE: begin
          if (par_req.wdata[7:0] <= 8'(BLOW_EXTERNAL_TIMED)) begin
            blowoff_mode_select_ff <= par_req.wdata[7:0];
          end
        end
        IDX_SUCTION_MODE:  suction_mode_select_ff       <= par_req.wdata[7:0];
        IDX_REG_SETPOINT:  regulation_setpoint_value_ff <= par_req.wdata;
        IDX_PUMP_SPEED:    pump_speed_percent_ff        <= par_req.wdata[7:0];
        IDX_PP_THRESHOLD:  part_present_threshold_ff    <= par_req.wdata;
        IDX_PP_HYSTERESIS: part_present_hysteresis_ff   <= par_req.wdata;
        IDX_BLOWOFF_TIME:  blowoff_duration_ff          <= par_req.wdata;
        IDX_EXT_LOCKS:     ext_locks_ff                 <= par_req.wdata[7:0];
        default: begin
        end
      endcase
    end
  end

  // Zero calibration on command, offset kept only when within limit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_offset_ff <= 16'h0000;
      zero_error_ff  <= 1'b0;
    end else if (par_req.wr && par_req.index == IDX_SYSTEM_COMMAND && par_req.wdata[7:0] == CMD_ZERO_ADJUST) begin
      if (32'(abs16(vacuum_raw)) * 32'd100 <= 32'(FULL_SCALE) * 32'(ZERO_LIMIT_PERCENT)) begin
        zero_offset_ff <= vacuum_raw;
        zero_error_ff  <= 1'b0;
      end else begin
        zero_error_ff  <= 1'b1;
      end
    end
  end

  // Readback answered one cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      par_rdata  <= 16'h0000;
      par_rvalid <= 1'b0;
    end else begin
      par_rvalid <= par_req.rd;
      if (par_req.rd) begin
        case (par_req.index)
          IDX_BLOWOFF_MODE:  par_rdata <= {8'h00, blowoff_mode_select_ff};
          IDX_IO_POLARITY:   par_rdata <= {14'h0000, pol_sync};
          IDX_SUCTION_MODE:  par_rdata <= {8'h00, suction_mode_select_ff};
          IDX_REG_SETPOINT:  par_rdata <= regulation_setpoint_value_ff;
          IDX_PUMP_SPEED:    par_rdata <= {8'h00, pump_speed_percent_ff};
          IDX_PP_THRESHOLD:  par_rdata <= part_present_threshold_ff;
          IDX_PP_HYSTERESIS: par_rdata <= part_present_hysteresis_ff;
          IDX_BLOWOFF_TIME:  par_rdata <= blowoff_duration_ff;
          IDX_EXT_LOCKS:     par_rdata <= {8'h00, ext_locks_ff};
          IDX_ZERO_OFFSET:   par_rdata <= zero_offset_ff;
          default:           par_rdata <= 16'h0000;
        endcase
      end
    end
  end

  // Request sources: process data on the link, pins in discrete mode
  assign suction_req = io_link_mode ? pd_out.suction : pins_sync[0];
  assign blowoff_req = io_link_mode ? pd_out.blowoff : pins_sync[1];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blowoff_req_d_ff <= 1'b0;
      suction_d_ff     <= 1'b0;
    end else begin
      blowoff_req_d_ff <= blowoff_req;
      suction_d_ff     <= suction_active;
    end
  end

  // Timed blowoff counter in whole milliseconds
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      blow_ms_ff   <= 16'h0000;
      blow_unit_ff <= '0;
    end else if ((blowoff_mode_select_ff == 8'(BLOW_INTERNAL_TIMED) && suction_d_ff && !suction_active) ||
                 (blowoff_mode_select_ff == 8'(BLOW_EXTERNAL_TIMED) && blowoff_req && !blowoff_req_d_ff)) begin
      blow_ms_ff   <= blowoff_duration_ff;
      blow_unit_ff <= UNIT_W'(BLOW_UNIT - 1);
    end else if (blow_ms_ff != 16'h0000) begin
      if (blow_unit_ff == '0) begin
        blow_ms_ff   <= blow_ms_ff - 16'h0001;
        blow_unit_ff <= UNIT_W'(BLOW_UNIT - 1);
      end else begin
        blow_unit_ff <= blow_unit_ff - 1'b1;
      end
    end
  end

  assign timed_blow = (blow_ms_ff != 16'h0000);

  always_comb begin
    case (blowoff_mode_select_ff)
      8'(BLOW_EXTERNAL):       blowoff_valve = blowoff_req;
      8'(BLOW_INTERNAL_TIMED): blowoff_valve = timed_blow || blowoff_req;
      8'(BLOW_EXTERNAL_TIMED): blowoff_valve = timed_blow;
      default:                 blowoff_valve = 1'b0;
    endcase
  end

  // Blowoff always wins over suction
  assign suction_active = suction_req && !blowoff_valve;

  // Mode and pump power selection
  assign cont_mode = io_link_mode ? pd_out.control_mode : suction_mode_select_ff[0];

  always_comb begin
    if (io_link_mode) begin
      if (pd_out.setpoint_ctrl == 8'h00) begin
        power_pct = clamp_percent(pump_speed_percent_ff);
      end else begin
        power_pct = clamp_percent(pd_out.setpoint_ctrl);
      end
    end else begin
      power_pct = clamp_percent(pump_speed_percent_ff);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pump_run           <= 1'b0;
      regulate_mode      <= 1'b0;
      pump_power_percent <= 8'h00;
      regulation_target  <= 16'h0000;
    end else begin
      regulate_mode      <= suction_active && !cont_mode;
      pump_run           <= suction_active && (!cont_mode || power_pct >= MOTOR_MIN_PERCENT);
      pump_power_percent <= (suction_active && cont_mode) ? power_pct : 8'h00;
      regulation_target  <= io_link_mode ? {8'h00, pd_out.regulation_setpoint}
                                         : regulation_setpoint_value_ff;
    end
  end

  // Part present with hysteresis on the zero-corrected vacuum
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      vacuum_corrected <= 16'h0000;
      part_present_ff  <= 1'b0;
    end else begin
      vacuum_corrected <= vacuum_raw - zero_offset_ff;
      if (vacuum_corrected >= part_present_threshold_ff) begin
        part_present_ff <= 1'b1;
      end else if ({1'b0, vacuum_corrected} + {1'b0, part_present_hysteresis_ff} <
                   {1'b0, part_present_threshold_ff}) begin
        part_present_ff <= 1'b0;
      end
    end
  end

  assign part_present_output = part_present_ff && !io_link_mode;

  // Button timing for the freedrive request
  assign both_pressed = pins_sync[2] && pins_sync[3] && !ext_locks_ff[LOCK_FREEDRIVE_BIT];
  assign any_pressed  = pins_sync[2] || pins_sync[3];
  assign fd_allowed   = !device_error && !threshold_adjust_active && !ext_locks_ff[LOCK_FREEDRIVE_BIT];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hold_cnt_ff <= '0;
      rel_cnt_ff  <= '0;
    end else begin
      if (!both_pressed) begin
        hold_cnt_ff <= '0;
      end else if (hold_cnt_ff != CNT_W'(HOLD_CNT)) begin
        hold_cnt_ff <= hold_cnt_ff + 1'b1;
      end
      if (any_pressed || fd_state_ff == FD_IDLE) begin
        rel_cnt_ff <= '0;
      end else if (rel_cnt_ff != CNT_W'(RELEASE_CNT)) begin
        rel_cnt_ff <= rel_cnt_ff + 1'b1;
      end
    end
  end

  always_comb begin
    nxt_fd_state = fd_state_ff;
    case (fd_state_ff)
      FD_IDLE: begin
        if (fd_allowed && hold_cnt_ff == CNT_W'(HOLD_CNT)) begin
          nxt_fd_state = io_link_mode ? FD_REQUESTED : FD_ACTIVE;
        end
      end
      FD_REQUESTED: begin
        if (rel_cnt_ff == CNT_W'(RELEASE_CNT)) begin
          nxt_fd_state = FD_IDLE;
        end else if (pd_out.freedrive_grant) begin
          nxt_fd_state = FD_ACTIVE;
        end
      end
      FD_ACTIVE: begin
        if (rel_cnt_ff == CNT_W'(RELEASE_CNT)) begin
          nxt_fd_state = FD_IDLE;
        end
      end
      default: nxt_fd_state = FD_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fd_state_ff <= FD_IDLE;
    end else begin
      fd_state_ff <= nxt_fd_state;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      manual_guide_output <= 1'b0;
      freedrive_indicator <= 1'b0;
      pd_in               <= '0;
    end else begin
      manual_guide_output       <= (nxt_fd_state == FD_ACTIVE) && !io_link_mode;
      freedrive_indicator       <= (nxt_fd_state == FD_ACTIVE);
      pd_in.freedrive_desired   <= (nxt_fd_state != FD_IDLE) && io_link_mode;
      pd_in.freedrive_active    <= (nxt_fd_state == FD_ACTIVE) && io_link_mode;
      pd_in.part_present        <= part_present_ff;
      pd_in.zero_cal_error      <= zero_error_ff;
    end
  end

  // Guide output stage is fixed sourcing whatever the switches say
  assign manual_guide_sourcing = 1'b1;

endmodule

// ---- logic/vsb_pkg.sv ----
// Package with parameter indexes, process data layout, codes and timing for the suction and blowoff control
// Functional notes
// - Command code 0xA5 written to the system command index starts a sensor zero calibration.
// - Zero offset accepted only within three percent of full scale; otherwise flag an error.
// - Suction mode comes from the process data bit, or from profile zero in discrete mode.
// - Control-mode bit one selects continuous suction at a demanded pump speed.
// - Discrete continuous suction uses the speed parameter; motor stands still below sixteen percent.
// - Setpoint byte is power in percent; above 100 gives full power.
// - Setpoint byte zero means use the speed stored in the active profile.
// - Regulation targets process byte one on the link, else the profile zero setpoint.
// - Part-present output sets at threshold, clears below threshold minus hysteresis.
// - Three blowoff modes: external level, internal timed, external triggered timed.
// - External mode vents exactly while the blowoff input is asserted.
// - Internal timed mode blows for the programmed duration whenever suction ends.
// - Blowoff beats suction; the blowoff input still starts blowoff in internal mode.
// - Triggered timed mode: input edge starts a fixed blowoff; holding does not extend.
// - Discrete mode: manual-guide output sets after both buttons held over one second.
// - Polarity switches are readable; the manual-guide output is always sourcing.
// - A freedrive request is only accepted without errors and outside threshold adjustment.
// - Link mode: valid two-button press sets the freedrive-desired flag only.
// - Host grant bit starts freedrive indication and the freedrive-activated confirmation.
// - Half a second with no button pressed leaves freedrive and drops the guide output.
// - Lock bit five ignores button presses and blocks any freedrive request.
package vsb_pkg;

  localparam logic [15:0] IDX_SYSTEM_COMMAND  = 16'h0002;
  localparam logic [15:0] IDX_BLOWOFF_MODE    = 16'h0045;
  localparam logic [15:0] IDX_IO_POLARITY     = 16'h0049;
  localparam logic [15:0] IDX_SUCTION_MODE    = 16'h004e;
  localparam logic [15:0] IDX_EXT_LOCKS       = 16'h005a;
  localparam logic [15:0] IDX_REG_SETPOINT    = 16'h0064;
  localparam logic [15:0] IDX_PUMP_SPEED      = 16'h0065;
  localparam logic [15:0] IDX_PP_THRESHOLD    = 16'h0066;
  localparam logic [15:0] IDX_PP_HYSTERESIS   = 16'h0067;
  localparam logic [15:0] IDX_BLOWOFF_TIME    = 16'h006a;
  localparam logic [15:0] IDX_ZERO_OFFSET     = 16'h0068;

  localparam logic [7:0]  CMD_ZERO_ADJUST     = 8'ha5;

  localparam int          LOCK_FREEDRIVE_BIT  = 5;
  localparam int          ZERO_LIMIT_PERCENT  = 3;
  localparam logic [7:0]  PERCENT_FULL        = 8'h64;
  localparam logic [7:0]  MOTOR_MIN_PERCENT   = 8'h10;

  localparam logic [7:0]  RST_BLOWOFF_MODE    = 8'h00;
  localparam logic [7:0]  RST_SUCTION_MODE    = 8'h00;
  localparam logic [15:0] RST_REG_SETPOINT    = 16'h0258;
  localparam logic [7:0]  RST_PUMP_SPEED      = 8'h64;
  localparam logic [15:0] RST_PP_THRESHOLD    = 16'h0190;
  localparam logic [15:0] RST_PP_HYSTERESIS   = 16'h0032;
  localparam logic [15:0] RST_BLOWOFF_TIME    = 16'h00c8;
  localparam logic [7:0]  RST_EXT_LOCKS       = 8'h00;

  localparam int          CLK_HZ              = 10_000_000;
  localparam int          HOLD_TIME_MS        = 1000;
  localparam int          RELEASE_TIME_MS     = 500;
  localparam int          BLOWOFF_UNIT_MS     = 1;
  localparam int          HOLD_CYCLES         = CLK_HZ / 1000 * HOLD_TIME_MS;
  localparam int          RELEASE_CYCLES      = CLK_HZ / 1000 * RELEASE_TIME_MS;
  localparam int          BLOWOFF_UNIT_CYCLES = CLK_HZ / 1000 * BLOWOFF_UNIT_MS;

  typedef enum logic [1:0] {
    BLOW_EXTERNAL,
    BLOW_INTERNAL_TIMED,
    BLOW_EXTERNAL_TIMED
  } vsb_blow_mode_t;

  typedef struct packed {
    logic       freedrive_grant;
    logic       control_mode;
    logic       blowoff;
    logic       suction;
    logic [7:0] setpoint_ctrl;
    logic [7:0] regulation_setpoint;
  } vsb_pd_out_t;

  typedef struct packed {
    logic freedrive_active;
    logic freedrive_desired;
    logic part_present;
    logic zero_cal_error;
  } vsb_pd_in_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [15:0] wdata;
  } vsb_par_req_t;

endpackage

// ---- logic/vsb_sync.sv ----
// Three-stage pin synchroniser that takes a new level once the second and third stages agree
`timescale 1ns/1ps
module vsb_sync
  import vsb_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;

  initial begin
    if (WIDTH < 1) begin
      $error("vsb_sync: WIDTH must be at least 1");
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end else begin
      s1_ff <= pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Output follows only bits whose last two stages agree
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      level <= '0;
    end else begin
      level <= (s3_ff & ~(s2_ff ^ s3_ff)) | (level & (s2_ff ^ s3_ff));
    end
  end

endmodule

// ---- sim/vsb_ctrl_monitor.sv ----
// Port checker for the suction, blowoff and freedrive control
`timescale 1ns/1ps
module vsb_ctrl_monitor
  import vsb_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst,
  input wire logic         io_link_mode,
  input wire logic         device_error,
  input wire logic         threshold_adjust_active,
  input wire vsb_pd_out_t  pd_out,
  input wire vsb_par_req_t par_req,
  input wire vsb_pd_in_t   pd_in,
  input wire logic         par_rvalid,
  input wire logic         part_present_output,
  input wire logic         manual_guide_output,
  input wire logic         manual_guide_sourcing,
  input wire logic         pump_run,
  input wire logic         regulate_mode,
  input wire logic [7:0]   pump_power_percent,
  input wire logic         blowoff_valve
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_blow_held;
    blowoff_valve [*2];
  endsequence
  sequence s_link_held;
    io_link_mode [*2];
  endsequence
  AST_SOURCING: assert property (manual_guide_sourcing)
    else $error("guide output not sourcing");
  AST_POL_READ: assert property (par_req.rd && par_req.index == IDX_IO_POLARITY |=> par_rvalid)
    else $error("no read answer");
  AST_ZERO_ERR: assert property ($rose(pd_in.zero_cal_error) |-> $past(par_req.wr) || $past(par_req.wr, 2))
    else $error("calibration error without command");
  AST_RUN_MIN: assert property (pump_run && !regulate_mode |-> pump_power_percent >= MOTOR_MIN_PERCENT)
    else $error("motor runs below minimum");
  AST_POWER_CAP: assert property (pump_power_percent <= PERCENT_FULL)
    else $error("power above full");
  AST_BLOW_WINS: assert property (s_blow_held |-> !pump_run)
    else $error("suction during blowoff");
  AST_PP_LINK: assert property (io_link_mode |-> !part_present_output)
    else $error("part present pin in link mode");
  AST_LINK_GUIDE: assert property (s_link_held |-> !manual_guide_output)
    else $error("guide output in link mode");
  AST_GRANT: assert property ($rose(pd_in.freedrive_active) |-> $past(pd_out.freedrive_grant))
    else $error("freedrive active without grant");
  AST_FD_BLOCK: assert property ($rose(pd_in.freedrive_desired) |-> !$past(device_error) && !$past(threshold_adjust_active))
    else $error("freedrive request while blocked");
endmodule

bind vsb_ctrl vsb_ctrl_monitor u_mon (
  .clk, .rst, .io_link_mode, .device_error, .threshold_adjust_active, .pd_out, .par_req, .pd_in, .par_rvalid,
  .part_present_output, .manual_guide_output, .manual_guide_sourcing, .pump_run, .regulate_mode,
  .pump_power_percent, .blowoff_valve
);

// ---- sim/vsb_host_model.sv ----
// Host side model: parameter access, process data and discrete pins
`timescale 1ns/1ps
module vsb_host_model
  import vsb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        grant_ok,
  input  wire vsb_pd_in_t  pd_in,
  input  wire logic [15:0] par_rdata,
  output vsb_pd_out_t      pd_out,
  output vsb_par_req_t     par_req,
  output logic             suction_request_input,
  output logic             blowoff_request_input
);
  vsb_pd_out_t pd_cmd;
  logic        grant_ff;
  initial begin
    pd_cmd = '0;
    par_req = '0;
    suction_request_input = 1'b0;
    blowoff_request_input = 1'b0;
  end
  // Grant stays up only while the device asks for or holds freedrive
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      grant_ff <= 1'b0;
    end else begin
      grant_ff <= grant_ok && (pd_in.freedrive_desired || pd_in.freedrive_active);
    end
  end
  always_comb begin
    pd_out = pd_cmd;
    pd_out.freedrive_grant = grant_ff;
  end
  task automatic par_write(input logic [15:0] i, input logic [15:0] d);
    @(posedge clk);
    par_req <= '{1'b1, 1'b0, i, d};
    @(posedge clk);
    par_req.wr <= 1'b0;
  endtask
  task automatic par_read(input logic [15:0] i, output logic [15:0] d);
    @(posedge clk);
    par_req <= '{1'b0, 1'b1, i, 16'h0000};
    @(posedge clk);
    par_req.rd <= 1'b0;
    #1 d = par_rdata;
  endtask
endmodule

// ---- sim/test_vacuum_suction_blowoff_control.sv ----
// Self-checking bench for the suction, blowoff and freedrive control
`timescale 1ns/1ps
module test_vacuum_suction_blowoff_control;
  import vsb_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         io_link_mode = 1'b0;
  logic         btn = 1'b0;
  logic         polarity_switch_inputs = 1'b0;
  logic         polarity_switch_output = 1'b0;
  logic         device_error = 1'b0;
  logic         threshold_adjust_active = 1'b0;
  logic         grant_ok = 1'b0;
  logic [15:0]  vacuum_raw = 16'h0000;
  logic         suction_request_input, blowoff_request_input, par_rvalid, part_present_output;
  logic         manual_guide_output, pump_run, regulate_mode, blowoff_valve, freedrive_indicator;
  logic [7:0]   pump_power_percent;
  logic [15:0]  par_rdata, regulation_target, vacuum_corrected;
  vsb_pd_out_t  pd_out;
  vsb_par_req_t par_req;
  vsb_pd_in_t   pd_in;
  int           mdl[int];
  int           bad_count = 0;
  int           num_checks = 0;

  always #50 clk = ~clk;

  vsb_host_model u_host (.*);
  vsb_ctrl #(.HOLD_CNT(20), .RELEASE_CNT(10), .BLOW_UNIT(4)) u_dut (
    .*, .button_left(btn), .button_right(btn), .manual_guide_sourcing());

  task automatic step(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [15:0] i);
    logic [15:0] d;
    u_host.par_read(i, d);
    chk(d, mdl.exists(i) ? 16'(mdl[i]) : 16'h0000);
  endtask
  task automatic wr(input logic [15:0] i, input logic [15:0] d);
    u_host.par_write(i, d);
    if (i inside {IDX_SUCTION_MODE, IDX_PUMP_SPEED, IDX_EXT_LOCKS} || (i == IDX_BLOWOFF_MODE && d <= 2)) mdl[i] = d[7:0];
    if (i inside {IDX_REG_SETPOINT, IDX_PP_THRESHOLD, IDX_PP_HYSTERESIS, IDX_BLOWOFF_TIME}) mdl[i] = d;
  endtask
  task automatic press(input int n);
    @(posedge clk);
    btn <= 1'b1;
    step(n);
  endtask
  task automatic rel;
    @(posedge clk);
    btn <= 1'b0;
    step(16);
  endtask
  // Pulses one pin for 20 cycles and counts valve cycles
  task automatic pulse(input bit s, output int n);
    n = 0;
    for (int c = 0; c < 45; c++) begin
      @(posedge clk);
      if (s) u_host.suction_request_input <= c < 20;
      else u_host.blowoff_request_input <= c < 20;
      #1 n += (blowoff_valve === 1'b1);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    results();
  end

  initial begin
    int idx[8] = '{'h45, 'h4e, 'h64, 'h65, 'h66, 'h67, 'h6a, 'h5a};
    int rv[8] = '{0, 0, 600, 100, 400, 50, 200, 0};
    int ok[8] = '{0, 0, 600, 70, 400, 50, 3, 0};
    int zr[5] = '{20, 30, 31, -30, 0};
    int pv[5] = '{399, 400, 350, 349, 399};
    int sp[7] = '{0, 50, 100, 101, 255, 15, 16};
    int n, p, e;
    logic [15:0] d;
    n = $urandom(77);
    @(posedge clk);
    polarity_switch_inputs <= 1'($urandom);
    polarity_switch_output <= 1'($urandom);
    step(2);
    rst <= 1'b0;
    foreach (idx[i]) mdl[idx[i]] = rv[i];
    mdl['h68] = 0;
    mdl['h49] = {polarity_switch_output, polarity_switch_inputs};
    step(4);
    foreach (idx[i]) rdchk(16'(idx[i]));
    rdchk(16'h0123);
    foreach (idx[i]) begin
      d = (i == 0) ? 16'($urandom_range(3)) : 16'($urandom);
      wr(16'(idx[i]), d);
      rdchk(16'(idx[i]));
    end
    wr(IDX_IO_POLARITY, 16'hffff);
    rdchk(IDX_IO_POLARITY);
    foreach (idx[i]) wr(16'(idx[i]), 16'(ok[i]));
    foreach (zr[i]) begin
      @(posedge clk);
      vacuum_raw <= 16'(zr[i]);
      wr(IDX_SYSTEM_COMMAND, 16'h00a5);
      e = ((zr[i] < 0 ? -zr[i] : zr[i]) * 100 > 1000 * ZERO_LIMIT_PERCENT);
      if (e == 0) mdl['h68] = zr[i] & 'hffff;
      step(3);
      chk(16'(pd_in.zero_cal_error), 16'(e));
      chk(vacuum_corrected, 16'(zr[i] - mdl['h68]));
      rdchk(IDX_ZERO_OFFSET);
    end
    e = 0;
    foreach (pv[i]) begin
      @(posedge clk);
      vacuum_raw <= 16'(pv[i]);
      step(4);
      if (pv[i] >= mdl['h66]) e = 1;
      else if (pv[i] + mdl['h67] < mdl['h66]) e = 0;
      chk(16'({part_present_output, pd_in.part_present}), 16'(e * 3));
    end
    @(posedge clk);
    io_link_mode <= 1'b1;
    u_host.pd_cmd.control_mode <= 1'b1;
    u_host.pd_cmd.suction <= 1'b1;
    foreach (sp[i]) begin
      @(posedge clk);
      u_host.pd_cmd.setpoint_ctrl <= 8'(sp[i]);
      step(3);
      p = sp[i] == 0 ? mdl['h65] : (sp[i] > 100 ? 100 : sp[i]);
      chk(16'(pump_power_percent), 16'(p));
      chk(16'({pump_run, regulate_mode}), 16'({p >= 16, 1'b0}));
    end
    @(posedge clk);
    u_host.pd_cmd.control_mode <= 1'b0;
    u_host.pd_cmd.regulation_setpoint <= 8'($urandom);
    step(3);
    chk(regulation_target, {8'h00, u_host.pd_cmd.regulation_setpoint});
    chk(16'(regulate_mode), 16'h0001);
    @(posedge clk);
    io_link_mode <= 1'b0;
    u_host.suction_request_input <= 1'b1;
    step(6);
    chk(regulation_target, 16'(mdl['h64]));
    wr(IDX_SUCTION_MODE, 16'h0001);
    for (int s = 12; s < 250; s += 60) begin
      wr(IDX_PUMP_SPEED, 16'(s));
      step(3);
      p = s > 100 ? 100 : s;
      chk(16'({pump_power_percent, pump_run}), 16'({8'(p), p >= 16}));
    end
    @(posedge clk);
    u_host.suction_request_input <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      wr(IDX_BLOWOFF_MODE, 16'(m == 3 ? 1 : m));
      pulse(m == 3, n);
      e = m > 1 ? mdl['h6a] * 4 : 20;
      if (m > 1 && (n - e) * (n - e) == 1) n = e;
      chk(16'(n), 16'(e));
    end
    press(10);
    chk(16'(manual_guide_output), 16'h0000);
    rel();
    press(30);
    chk(16'({manual_guide_output, freedrive_indicator}), 16'h0003);
    rel();
    chk(16'(manual_guide_output), 16'h0000);
    @(posedge clk);
    io_link_mode <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      device_error <= b == 0;
      threshold_adjust_active <= b == 1;
      wr(IDX_EXT_LOCKS, b == 2 ? 16'h0020 : 16'h0000);
      press(30);
      chk(16'({pd_in.freedrive_desired, pd_in.freedrive_active, manual_guide_output}), b == 3 ? 16'h0004 : 16'h0000);
      if (b == 3) begin
        @(posedge clk);
        grant_ok <= 1'b1;
        step(4);
        chk(16'({pd_in.freedrive_active, freedrive_indicator}), 16'h0003);
      end
      rel();
      chk(16'({pd_in.freedrive_desired, pd_in.freedrive_active}), 16'h0000);
    end
    results();
  end
endmodule
